//--- hw/ecb_encoder_capture_breakpoint.sv
// four-channel encoder counter with index/trigger capture and breakpoint outputs
`timescale 1ns/100ps

// What this block does
// - quadrature A/B decoded into 32-bit up/down count on all four transitions.
// - A, B and index pass a programmable glitch filter before use.
// - each channel's A, B and index polarity inverts independently.
// - index search latches the count on a qualified index rise.
// - default index qualifier is index high with A and B low.
// - software picks which A/B state qualifies the index.
// - index search completes only when an index edge is seen.
// - enabled trigger edge latches that channel's count after a two-stage synchroniser.
// - each trigger's active edge is rising or falling, software chosen.
// - capture flag doubles as a latched general-purpose input.
// - relative-to-capture mode gives target as capture plus offset.
// - enabled shutdown asserts inhibits, zeroes analog, halts stepping.
// - shutdown fires only on a rising edge.
// - breakpoint output changes when count equals breakpoint position.
// - breakpoint is absolute, modulo or relative to current count.
// - output presettable; match sets, clears or toggles it.
// - software can set or clear each breakpoint output directly.
// - routed breakpoint emits 200 ns high pulse on trigger bus.
module ecb_encoder_capture_breakpoint
    import ecb_pkg::*;
#(
    parameter int unsigned CH     = NUM_CH,
    parameter int unsigned FLT_W  = FILT_W
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    // encoder pins
    input  wire logic [CH-1:0]        enc_a,
    input  wire logic [CH-1:0]        enc_b,
    input  wire logic [CH-1:0]        enc_idx,
    // input conditioning
    input  wire logic [CH-1:0]        inv_a,
    input  wire logic [CH-1:0]        inv_b,
    input  wire logic [CH-1:0]        inv_idx,
    input  wire logic [FLT_W-1:0]     filt_len,
    // index search
    input  wire logic [CH-1:0]        idx_search_start,
    input  wire logic [CH*2-1:0]      idx_pattern,
    output logic      [CH-1:0]        idx_search_busy,
    output logic      [CH-1:0]        idx_found,
    output logic      [CH*POS_W-1:0]  idx_pos,
    // trigger capture
    input  wire logic [CH-1:0]        trig_in,
    input  wire logic [CH-1:0]        trig_en,
    input  wire logic [CH-1:0]        trig_inv,
    input  wire logic [CH-1:0]        cap_read,
    output logic      [CH-1:0]        cap_flag,
    output logic      [CH*POS_W-1:0]  cap_pos,
    // capture-relative move
    input  wire logic [CH*POS_W-1:0]  rel_offset,
    output logic      [CH*POS_W-1:0]  rel_target,
    // position counters
    output logic      [CH*POS_W-1:0]  enc_count,
    // shutdown
    input  wire logic                 shutdown_in,
    input  wire logic                 shutdown_en,
    input  wire logic                 shutdown_clear,
    output logic                      shutdown_active,
    output logic      [CH-1:0]        axis_inhibit,
    output logic                      analog_zero,
    output logic                      step_halt,
    // breakpoints
    input  wire logic [CH-1:0]        bp_arm,
    input  wire logic [CH*2-1:0]      bp_mode,
    input  wire logic [CH*2-1:0]      bp_action,
    input  wire logic [CH*POS_W-1:0]  bp_value,
    input  wire logic [CH*POS_W-1:0]  bp_period,
    input  wire logic [CH-1:0]        bp_preset,
    input  wire logic [CH-1:0]        bp_preset_lvl,
    input  wire logic [CH-1:0]        bp_force_set,
    input  wire logic [CH-1:0]        bp_force_clr,
    input  wire logic [CH-1:0]        bp_route,
    output logic      [CH-1:0]        bp_armed,
    output logic      [CH-1:0]        bp_out,
    output logic      [CH-1:0]        bp_trig_bus
);
    localparam int unsigned PW = $clog2(BP_PULSE_CYC + 1);

    // the packed per-channel state grows fast; wider settings are not served
    if (CH < 1 || CH > 8 || FLT_W < 1 || FLT_W > 8) begin : g_bad_params
        $error("unsupported channel count or filter width");
    end

    typedef struct packed {
        logic [2:0]       s1;          // sync stage 1: a,b,idx
        logic [2:0]       s2;
        logic [2:0]       filt;        // filtered, polarity applied
        logic [2:0][FLT_W-1:0] fcnt;
        logic [1:0]       s_trig;
        logic             trig_prev;
        logic [POS_W-1:0] count;
        logic             srch;
        logic             found;
        logic [POS_W-1:0] ipos;
        logic             cflag;
        logic [POS_W-1:0] cpos;
        logic             barmed;
        logic [POS_W-1:0] btarget;
        logic             bout;
        logic [PW-1:0]    pulse;
    } ecb_ch_t;

    typedef struct packed {
        ecb_ch_t [CH-1:0] ch;
        logic [1:0]       s_sd;
        logic             sd_prev;
        logic             sd;
    } ecb_state_t;

    ecb_state_t st_q, st_d;

    always_comb begin
        logic [2:0]       raw;
        logic [1:0]       ab_old;
        logic [1:0]       ab_new;
        logic [POS_W-1:0] cnt;
        logic             t_act;
        logic             idx_rise;
        logic [POS_W-1:0] per;
        logic [POS_W-1:0] tgt;
        logic [1:0]       act;
        logic [2:0]       inv;
        raw      = '0;
        inv      = '0;
        ab_old   = '0;
        ab_new   = '0;
        cnt      = '0;
        t_act    = 1'b0;
        idx_rise = 1'b0;
        per      = '0;
        tgt      = '0;
        act      = '0;
        st_d = st_q;
        for (int i = 0; i < CH; i++) begin
            raw = {enc_idx[i], enc_b[i], enc_a[i]};
            inv = {inv_idx[i], inv_b[i], inv_a[i]};
            st_d.ch[i].s1 = raw;
            st_d.ch[i].s2 = st_q.ch[i].s1;
            for (int k = 0; k < 3; k++) begin
                if ((st_q.ch[i].s2[k] ^ inv[k]) == st_q.ch[i].filt[k]) begin
                    st_d.ch[i].fcnt[k] = '0;
                end else if (st_q.ch[i].fcnt[k] >= filt_len) begin
                    st_d.ch[i].filt[k] = ~st_q.ch[i].filt[k];
                    st_d.ch[i].fcnt[k] = '0;
                end else begin
                    st_d.ch[i].fcnt[k] = st_q.ch[i].fcnt[k] + 1'b1;
                end
            end
            // quadrature step: gray-code transitions only, double steps dropped
            ab_old = st_q.ch[i].filt[1:0];
            ab_new = st_d.ch[i].filt[1:0];
            cnt = st_q.ch[i].count;
            if (ab_old != ab_new && (ab_old ^ ab_new) != 2'h3) begin
                if ((ab_old[0] ^ ab_new[1]) == 1'b0) begin
                    cnt = cnt + 32'h0000_0001;
                end else begin
                    cnt = cnt - 32'h0000_0001;
                end
            end
            st_d.ch[i].count = cnt;
            // index search
            idx_rise = st_d.ch[i].filt[2] & ~st_q.ch[i].filt[2];
            if (idx_search_start[i]) begin
                st_d.ch[i].srch  = 1'b1;
                st_d.ch[i].found = 1'b0;
            end else if (st_q.ch[i].srch && idx_rise
                    && ab_new == idx_pattern[i*2 +: 2]) begin
                st_d.ch[i].srch  = 1'b0;
                st_d.ch[i].found = 1'b1;
                st_d.ch[i].ipos  = cnt;
            end
            // trigger capture
            st_d.ch[i].s_trig = {st_q.ch[i].s_trig[0], trig_in[i]};
            st_d.ch[i].trig_prev = st_q.ch[i].s_trig[1] ^ trig_inv[i];
            t_act = (st_q.ch[i].s_trig[1] ^ trig_inv[i]) & ~st_q.ch[i].trig_prev;
            if (trig_en[i] && t_act) begin
                st_d.ch[i].cpos  = st_q.ch[i].count;
                st_d.ch[i].cflag = 1'b1;
            end else if (cap_read[i]) begin
                st_d.ch[i].cflag = 1'b0;
            end
            // breakpoint
            per = bp_period[i*POS_W +: POS_W];
            act = bp_action[i*2 +: 2];
            if (bp_arm[i]) begin
                st_d.ch[i].barmed = 1'b1;
                if (bp_mode[i*2 +: 2] == ECB_BP_REL) begin
                    st_d.ch[i].btarget = cnt + bp_value[i*POS_W +: POS_W];
                end else begin
                    st_d.ch[i].btarget = bp_value[i*POS_W +: POS_W];
                end
            end
            tgt = st_q.ch[i].btarget;
            if (st_q.ch[i].barmed && !bp_arm[i] &&
                    ((bp_mode[i*2 +: 2] == ECB_BP_MOD && per != '0)
                        ? (cnt % per) == tgt : cnt == tgt)) begin
                st_d.ch[i].barmed = 1'b0;
                st_d.ch[i].pulse  = PW'(BP_PULSE_CYC);
                case (act)
                    ECB_ACT_SET: st_d.ch[i].bout = 1'b1;
                    ECB_ACT_CLR: st_d.ch[i].bout = 1'b0;
                    default:     st_d.ch[i].bout = ~st_q.ch[i].bout;
                endcase
            end else if (st_q.ch[i].pulse != '0) begin
                st_d.ch[i].pulse = st_q.ch[i].pulse - 1'b1;
            end
            if (bp_force_set[i]) begin
                st_d.ch[i].bout = 1'b1;
            end else if (bp_force_clr[i]) begin
                st_d.ch[i].bout = 1'b0;
            end else if (bp_preset[i]) begin
                st_d.ch[i].bout = bp_preset_lvl[i];
            end
        end
        // shutdown: rising edge only, sticky until cleared
        st_d.s_sd = {st_q.s_sd[0], shutdown_in};
        st_d.sd_prev = st_q.s_sd[1];
        if (shutdown_en && st_q.s_sd[1] && !st_q.sd_prev) begin
            st_d.sd = 1'b1;
        end else if (shutdown_clear) begin
            st_d.sd = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_q <= '0;
            for (int i = 0; i < CH; i++) begin
                st_q.ch[i].count <= POS_RST;
                st_q.ch[i].bout  <= BP_OUT_RST;
            end
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        for (int i = 0; i < CH; i++) begin
            idx_search_busy[i]         = st_q.ch[i].srch;
            idx_found[i]               = st_q.ch[i].found;
            idx_pos[i*POS_W +: POS_W]  = st_q.ch[i].ipos;
            cap_flag[i]                = st_q.ch[i].cflag;
            cap_pos[i*POS_W +: POS_W]  = st_q.ch[i].cpos;
            rel_target[i*POS_W +: POS_W] = st_q.ch[i].cpos
                + rel_offset[i*POS_W +: POS_W];
            enc_count[i*POS_W +: POS_W] = st_q.ch[i].count;
            bp_armed[i]                = st_q.ch[i].barmed;
            bp_out[i]                  = st_q.ch[i].bout;
            bp_trig_bus[i]             = bp_route[i] & (st_q.ch[i].pulse != '0);
            axis_inhibit[i]            = st_q.sd;
        end
        shutdown_active = st_q.sd;
        analog_zero     = st_q.sd;
        step_halt       = st_q.sd;
    end

    // shutdown must follow a rising edge within 4 cycles
    sd_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(shutdown_in) && shutdown_en ##1 shutdown_en[*2] |-> ##[1:2] shutdown_active)
        else $error("shutdown missed rising edge");
    sd_static_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(shutdown_active) |-> $past(shutdown_en)
            && $past(st_q.s_sd[1]) && !$past(st_q.sd_prev))
        else $error("shutdown without edge");
    sd_outputs_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        shutdown_active |-> (&axis_inhibit) && analog_zero && step_halt)
        else $error("shutdown outputs incomplete");
    cap_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !(trig_en[0] && st_d.ch[0].trig_prev && !st_q.ch[0].trig_prev)
            |=> $stable(cap_pos[POS_W-1:0]))
        else $error("capture changed without event");
    cap_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        trig_en[0] && (st_q.ch[0].s_trig[1] ^ trig_inv[0]) && !st_q.ch[0].trig_prev
            |=> cap_flag[0] && cap_pos[POS_W-1:0] == $past(enc_count[POS_W-1:0]))
        else $error("trigger capture missed");
    count_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        enc_count[POS_W-1:0] - $past(enc_count[POS_W-1:0]) inside {32'h0, 32'h1, 32'hffff_ffff})
        else $error("count jumped more than one");
    idx_latch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(idx_found[0]) |-> idx_pos[POS_W-1:0] == enc_count[POS_W-1:0])
        else $error("index position not latched");
    bp_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(bp_armed[0])
            |-> (bp_trig_bus[0] == bp_route[0])[*4] ##1 !bp_trig_bus[0])
        else $error("breakpoint pulse length wrong");
    bp_force_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bp_force_set[0] |=> bp_out[0])
        else $error("force set ignored");
    // a match in the arming cycle is refused, so arming always leaves it armed
    bp_arm_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bp_arm[0] |=> bp_armed[0])
        else $error("arming did not take");
    bp_force_clr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bp_force_clr[0] && !bp_force_set[0] |=> !bp_out[0])
        else $error("force clear ignored");
    bp_preset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bp_preset[0] && !bp_force_set[0] && !bp_force_clr[0]
            |=> bp_out[0] == $past(bp_preset_lvl[0]))
        else $error("preset level not applied");
    bp_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !bp_armed[0] && !bp_force_set[0] && !bp_force_clr[0] && !bp_preset[0]
            |=> $stable(bp_out[0]))
        else $error("breakpoint output moved while idle");
    bp_set_act_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(bp_armed[0]) && $past(bp_action[1:0]) == ECB_ACT_SET
            && !$past(bp_force_clr[0]) && !$past(bp_preset[0]) |-> bp_out[0])
        else $error("set action not applied");
    bp_clr_act_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(bp_armed[0]) && $past(bp_action[1:0]) == ECB_ACT_CLR
            && !$past(bp_force_set[0]) && !$past(bp_preset[0]) |-> !bp_out[0])
        else $error("clear action not applied");
    bp_tgl_act_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(bp_armed[0]) && $past(bp_action[1:0]) == ECB_ACT_TGL
            && !$past(bp_force_set[0]) && !$past(bp_force_clr[0]) && !$past(bp_preset[0])
            |-> bp_out[0] != $past(bp_out[0]))
        else $error("toggle action not applied");
    cap_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !trig_en[0] |=> $stable(cap_pos[POS_W-1:0]))
        else $error("capture while disabled");
    cap_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cap_read[0] && !(trig_en[0] && st_d.ch[0].trig_prev && !st_q.ch[0].trig_prev)
            |=> !cap_flag[0])
        else $error("flag not cleared by read");
    idx_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        idx_search_start[0] |=> idx_search_busy[0] && !idx_found[0])
        else $error("index search did not start");
    idx_qual_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(idx_found[0]) |-> st_q.ch[0].filt == {1'b1, $past(idx_pattern[1:0])})
        else $error("index found off pattern");
    idx_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !$rose(idx_found[0]) |-> $stable(idx_pos[POS_W-1:0]))
        else $error("index position moved");
    // a filtered level may only flip once the run length has been reached
    filt_wait_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $changed(st_q.ch[0].filt[0]) |-> $past(st_q.ch[0].fcnt[0]) >= $past(filt_len))
        else $error("filter passed a short pulse");
    sd_sticky_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        shutdown_active && !shutdown_clear |=> shutdown_active)
        else $error("shutdown dropped without clear");
    sd_enable_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !shutdown_en |=> !$rose(shutdown_active))
        else $error("shutdown while disabled");
endmodule

//--- hw/ecb_pkg.sv
// shared constants for the encoder capture and breakpoint block
package ecb_pkg;
    localparam int unsigned NUM_CH          = 4;
    localparam int unsigned POS_W           = 32;
    localparam int unsigned FILT_W          = 4;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned BP_PULSE_NS     = 200;
    localparam int unsigned BP_PULSE_CYC    =
        (BP_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [1:0]  IDX_PAT_RST     = 2'h0;
    localparam logic [31:0] POS_RST         = 32'h0000_0000;
    localparam logic        BP_OUT_RST      = 1'b0;

    typedef enum logic [1:0] {
        ECB_BP_ABS,
        ECB_BP_MOD,
        ECB_BP_REL
    } ecb_bp_mode_t;

    typedef enum logic [1:0] {
        ECB_ACT_SET,
        ECB_ACT_CLR,
        ECB_ACT_TGL
    } ecb_bp_act_t;
endpackage

//--- testbench/ecb_enc_model.sv
// incremental encoder model: quadrature phases and index for one channel
`timescale 1ns/100ps
module ecb_enc_model (
    // clock
    input  wire logic ref_clk,
    // encoder lines
    output logic      pha,
    output logic      phb,
    output logic      idx
);
    logic [1:0] ph = 2'h0;

    // only one phase changes per step, a quarter period apart (gray order)
    assign pha = ph[1] ^ ph[0];
    assign phb = ph[1];
    initial idx = 1'b0;

    // each step is held long enough to clear the synchroniser and filter
    task automatic step(input logic up, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #2;
            ph = up ? ph + 2'h1 : ph - 2'h1;
            repeat (8) @(posedge ref_clk);
        end
        #2;
    endtask

    task automatic index_pulse();
        @(posedge ref_clk);
        #2;
        idx = 1'b1;
        repeat (8) @(posedge ref_clk);
        #2;
        idx = 1'b0;
        repeat (8) @(posedge ref_clk);
        #2;
    endtask
endmodule

//--- testbench/tb_encoder_capture_breakpoint.sv
// self-checking bench for the encoder capture and breakpoint block
`timescale 1ns/100ps
module tb_encoder_capture_breakpoint;
    import ecb_pkg::*;
    logic         ref_clk, reset_n, shutdown_in, shutdown_en, shutdown_clear;
    logic         m_a, m_b, m_i, shutdown_active, analog_zero, step_halt;
    logic [3:0]   enc_a, enc_b, enc_idx, inv_a, inv_b, inv_idx, filt_len, trig_in;
    logic [3:0]   idx_search_start, idx_search_busy, idx_found, trig_en, trig_inv;
    logic [3:0]   cap_read, cap_flag, axis_inhibit, bp_arm, bp_preset, bp_preset_lvl;
    logic [3:0]   bp_force_set, bp_force_clr, bp_route, bp_armed, bp_out, bp_trig_bus;
    logic [7:0]   idx_pattern, bp_mode, bp_action;
    logic [127:0] idx_pos, cap_pos, rel_offset, rel_target, enc_count, bp_value, bp_period;
    logic [2:0]   aux_a;
    int           n_mismatch, cmp_count, cyc, hi;

    assign enc_a   = {aux_a, m_a};
    assign enc_b   = {3'h0, m_b};
    assign enc_idx = {3'h0, m_i};

    ecb_enc_model enc (.ref_clk(ref_clk), .pha(m_a), .phb(m_b), .idx(m_i));

    ecb_encoder_capture_breakpoint #(.CH(4), .FLT_W(4)) DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .enc_a(enc_a), .enc_b(enc_b),
        .enc_idx(enc_idx), .inv_a(inv_a), .inv_b(inv_b), .inv_idx(inv_idx),
        .filt_len(filt_len), .idx_search_start(idx_search_start),
        .idx_pattern(idx_pattern), .idx_search_busy(idx_search_busy),
        .idx_found(idx_found), .idx_pos(idx_pos), .trig_in(trig_in), .trig_en(trig_en),
        .trig_inv(trig_inv), .cap_read(cap_read), .cap_flag(cap_flag), .cap_pos(cap_pos),
        .rel_offset(rel_offset), .rel_target(rel_target), .enc_count(enc_count),
        .shutdown_in(shutdown_in), .shutdown_en(shutdown_en),
        .shutdown_clear(shutdown_clear), .shutdown_active(shutdown_active),
        .axis_inhibit(axis_inhibit), .analog_zero(analog_zero), .step_halt(step_halt),
        .bp_arm(bp_arm), .bp_mode(bp_mode), .bp_action(bp_action), .bp_value(bp_value),
        .bp_period(bp_period), .bp_preset(bp_preset), .bp_preset_lvl(bp_preset_lvl),
        .bp_force_set(bp_force_set), .bp_force_clr(bp_force_clr), .bp_route(bp_route),
        .bp_armed(bp_armed), .bp_out(bp_out), .bp_trig_bus(bp_trig_bus)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (bp_trig_bus[0] === 1'b1) hi++;
        if (cyc == 6000) begin
            n_mismatch++;
            $display("ERROR %0t run did not finish in time", $time);
            stop_test();
        end
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    // single-cycle request on channel 0 of a pulse input
    task automatic pulse(ref logic [3:0] s);
        s = 4'h1;
        tick(1);
        s = 4'h0;
        tick(2);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        {reset_n, shutdown_in, shutdown_en, shutdown_clear} = 4'h0;
        {inv_a, inv_b, inv_idx, filt_len, trig_in, idx_search_start} = 24'h0;
        {trig_en, trig_inv, cap_read, bp_arm, bp_preset, bp_preset_lvl} = 24'h0;
        {bp_force_set, bp_force_clr, bp_route, idx_pattern, bp_mode, bp_action} = 36'h0;
        {rel_offset, bp_value, bp_period} = '0;
        aux_a = 3'h0;
        repeat (12) @(posedge ref_clk);
        #2;
        reset_n = 1'b1;
        tick(2);
        enc.step(1'b1, 5);
        chk(enc_count[31:0], 32'h5, "count up");
        enc.step(1'b0, 1);
        chk(enc_count[31:0], 32'h4, "count down");
        $display("test counting done");
        filt_len = 4'h3;
        aux_a = 3'h1;
        tick(2);
        aux_a = 3'h0;
        tick(8);
        chk(enc_count[63:32], 32'h0, "glitch filtered");
        aux_a = 3'h1;
        tick(10);
        chk(enc_count[63:32], 32'h1, "long pulse counted");
        filt_len = 4'h0;
        $display("test filter done");
        idx_pattern = 8'h03;
        pulse(idx_search_start);
        enc.index_pulse();
        chk({idx_search_busy[0], idx_found[0]}, 32'h2, "unqualified index");
        idx_pattern = 8'h00;
        pulse(idx_search_start);
        enc.index_pulse();
        chk({idx_search_busy[0], idx_found[0]}, 32'h1, "index found");
        chk(idx_pos[31:0], 32'h4, "index position");
        $display("test index done");
        inv_a = 4'h1;
        tick(8);
        chk(enc_count[31:0], 32'h5, "inverted phase a");
        enc.step(1'b1, 1);
        chk(enc_count[31:0], 32'h4, "inverted direction");
        inv_a = 4'h0;
        tick(8);
        chk(enc_count[31:0], 32'h5, "polarity restored");
        $display("test polarity done");
        trig_in = 4'h1;
        tick(8);
        chk(cap_flag[0], 32'h0, "disabled trigger");
        trig_in = 4'h0;
        trig_en = 4'h1;
        rel_offset[31:0] = 32'h64;
        tick(8);
        trig_in = 4'h1;
        tick(8);
        chk({cap_flag[0], cap_pos[31:0]}, 33'h100000005, "rising capture");
        chk(rel_target[31:0], 32'h69, "relative target");
        enc.step(1'b1, 1);
        trig_inv = 4'h1;
        pulse(cap_read);
        chk({cap_flag[0], cap_pos[31:0]}, 33'h000000005, "flag read, value held");
        trig_in = 4'h0;
        tick(8);
        chk({cap_flag[0], cap_pos[31:0]}, 33'h100000006, "falling capture");
        $display("test capture done");
        bp_route = 4'h1;
        bp_value[31:0] = 32'h8;
        pulse(bp_arm);
        chk(bp_armed[0], 32'h1, "armed");
        hi = 0;
        enc.step(1'b1, 2);
        chk(bp_out[0], 32'h1, "absolute match sets");
        chk(hi, BP_PULSE_CYC, "trigger bus pulse");
        pulse(bp_force_clr);
        chk(bp_out[0], 32'h0, "force clear");
        pulse(bp_force_set);
        chk(bp_out[0], 32'h1, "force set");
        bp_mode = 8'h02;
        bp_action = 8'h02;
        bp_value[31:0] = 32'h2;
        pulse(bp_arm);
        enc.step(1'b1, 1);
        chk(bp_out[0], 32'h1, "no early match");
        enc.step(1'b1, 1);
        chk(bp_out[0], 32'h0, "relative toggle");
        bp_preset_lvl = 4'h1;
        pulse(bp_preset);
        chk(bp_out[0], 32'h1, "preset high");
        bp_mode = 8'h01;
        bp_action = 8'h01;
        bp_period[31:0] = 32'h4;
        bp_value[31:0] = 32'h3;
        pulse(bp_arm);
        enc.step(1'b1, 1);
        chk(bp_out[0], 32'h0, "modulo match clears");
        $display("test breakpoint done");
        shutdown_in = 1'b1;
        tick(8);
        shutdown_en = 1'b1;
        tick(8);
        chk(shutdown_active, 32'h0, "static high ignored");
        shutdown_in = 1'b0;
        tick(8);
        shutdown_in = 1'b1;
        tick(8);
        chk({shutdown_active, axis_inhibit, analog_zero, step_halt}, 32'h7f, "shutdown");
        shutdown_clear = 1'b1;
        tick(1);
        shutdown_clear = 1'b0;
        tick(2);
        chk(shutdown_active, 32'h0, "shutdown cleared");
        $display("test shutdown done");
        stop_test();
    end
endmodule
